// *** logic/cfg_bus_master.sv ***
// Word-addressed configuration bus master engine
`timescale 1ns/1ps
module cfg_bus_master
  import tx_link_host_pkg::*;
#(
  parameter bit USE_SELECT = 1'b1
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Command side
  cfg_req_if.engine req,
  // Configuration bus
  output logic cfg_bus_select_o,
  output logic [CFG_ADDR_W-1:0] cfg_bus_word_addr_o,
  output logic [CFG_DATA_W-1:0] cfg_bus_wr_word_o,
  output logic cfg_bus_rd_strobe_o,
  output logic cfg_bus_wr_strobe_o,
  input wire logic [CFG_DATA_W-1:0] cfg_bus_rd_word_i,
  input wire logic cfg_bus_stall_i
);
  typedef enum logic {ST_IDLE, ST_ACCESS} bus_state_t;
  bus_state_t state;
  logic write_pending;

  ////////////////////////////////////////////////////////////////////////////
  // Ready only when idle and the port is out of reset
  assign req.req_ready = (state == ST_IDLE) && req.port_live;

  // Access sequencer; strobes stand until the slave stops stalling
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      state <= ST_IDLE;
      write_pending <= 1'b0;
      cfg_bus_rd_strobe_o <= 1'b0;
      cfg_bus_wr_strobe_o <= 1'b0;
      cfg_bus_word_addr_o <= '0;
      cfg_bus_wr_word_o <= WORD_RESET;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (req.req_valid && req.req_ready)
          begin
            cfg_bus_word_addr_o <= req.req_addr; // Word index, no byte offset [RULE6]
            cfg_bus_wr_word_o <= req.req_wdata; // Full 32-bit word [RULE7]
            cfg_bus_wr_strobe_o <= req.req_write; // Active-high strobes [RULE8]
            cfg_bus_rd_strobe_o <= !req.req_write; // [RULE8]
            write_pending <= req.req_write;
            state <= ST_ACCESS;
          end
        end
        ST_ACCESS:
        begin
          // The slave never stalls, but a stall is still honoured [RULE9]
          if (!cfg_bus_stall_i)
          begin
            cfg_bus_rd_strobe_o <= 1'b0;
            cfg_bus_wr_strobe_o <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Select qualifies each strobe, or stands high when not used [RULE4] [RULE5]
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      cfg_bus_select_o <= !USE_SELECT;
    else if (!USE_SELECT)
      cfg_bus_select_o <= 1'b1; // [RULE5]
    else if (state == ST_IDLE)
      cfg_bus_select_o <= req.req_valid && req.req_ready;
    else if (!cfg_bus_stall_i)
      cfg_bus_select_o <= 1'b0;
  end

  // Read data is valid in the access cycle itself, so capture it there [RULE9]
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      req.rsp_valid <= 1'b0;
      req.rsp_rdata <= WORD_RESET;
    end
    else
    begin
      req.rsp_valid <= (state == ST_ACCESS) && !cfg_bus_stall_i;
      if ((state == ST_ACCESS) && !cfg_bus_stall_i && !write_pending)
        req.rsp_rdata <= cfg_bus_rd_word_i;
    end
  end
endmodule : cfg_bus_master

// *** logic/cfg_req_if.sv ***
// Request and answer bundle between the controller top and its bus engine
`timescale 1ns/1ps
interface cfg_req_if;
  import tx_link_host_pkg::*;
  logic req_valid;
  logic req_ready;
  logic req_write;
  logic [CFG_ADDR_W-1:0] req_addr;
  logic [CFG_DATA_W-1:0] req_wdata;
  logic rsp_valid;
  logic [CFG_DATA_W-1:0] rsp_rdata;
  logic port_live;

  modport ctrl (output req_valid, req_write, req_addr, req_wdata, port_live,
                input req_ready, rsp_valid, rsp_rdata);
  modport engine (input req_valid, req_write, req_addr, req_wdata, port_live,
                  output req_ready, rsp_valid, rsp_rdata);
endinterface : cfg_req_if

// *** logic/tx_link_host.sv ***
// Host controller for the transmit-link core: config bus, SYSREF, sync lines, lane data
// Operation
// RULE1: Device config port runs on its own clock, 75 to 125 MHz. Here it shares sys_clk_i, which the bench runs at 40 MHz.
// RULE2: Config reset may assert at once; its release follows the config clock.
// RULE3: No register access before the config reset has been released.
// RULE4: Device ignores bus inputs unless select is high; select qualifies access.
// RULE5: Without a select on the host bus, hold select at one.
// RULE6: Address is an 8-bit word index, one step per 32-bit word.
// RULE7: Write and read data are both 32 bits wide.
// RULE8: Active-high read strobe requests a read, write strobe a write.
// RULE9: Device never stalls and returns read data in the access cycle.
// RULE10: SYSREF is used only in subclass 1; otherwise it is held at zero.
// RULE11: Low sync line means either sync request or error report.
// RULE12: Sync request holds sync low for five frames plus nine octets.
// RULE13: Error pulse lasts one link cycle or two frame cycles, longer wins.
// RULE14: Device clean sync output goes low for requests, not for error reports.
// RULE15: Device clean sync output also goes low on software sync start.
// RULE16: Subclass 0 combines all links' clean sync outputs into multidevice sync.
// RULE17: Subclass 1 or single link feeds each clean sync straight back.
// RULE18: Device start-of-multiframe flag bit 3 marks octet 31:24, bit 0 octet 7:0.
// RULE19: Lane words are big-endian, lane 0 in the lowest 32 bits.
// RULE20: Device synchronises sync inputs and crosses config values safely.
`timescale 1ns/1ps
module tx_link_host
  import tx_link_host_pkg::*;
#(
  parameter int NUM_LINKS = 1,
  parameter int NUM_LANES = 1,
  parameter int OCTETS_PER_FRAME = 1,
  parameter int LINK_DIV = 1,
  parameter bit USE_SELECT = 1'b1
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Command port
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [tx_link_host_pkg::CFG_ADDR_W-1:0] cmd_addr_i,
  input wire logic [tx_link_host_pkg::CFG_DATA_W-1:0] cmd_wdata_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [tx_link_host_pkg::CFG_DATA_W-1:0] rsp_rdata_o,
  // Configuration bus toward the device
  output logic cfg_bus_reset_low_o,
  output logic cfg_bus_select_o,
  output logic [tx_link_host_pkg::CFG_ADDR_W-1:0] cfg_bus_word_addr_o,
  output logic [tx_link_host_pkg::CFG_DATA_W-1:0] cfg_bus_wr_word_o,
  output logic cfg_bus_rd_strobe_o,
  output logic cfg_bus_wr_strobe_o,
  input wire logic [tx_link_host_pkg::CFG_DATA_W-1:0] cfg_bus_rd_word_i,
  input wire logic cfg_bus_stall_i,
  // Link control
  input wire logic [1:0] subclass_i,
  input wire logic sysref_i,
  output logic sysref_o,
  input wire logic sync_req_i,
  input wire logic err_report_i,
  output logic sync_low_o,
  output logic sync_busy_o,
  // Multidevice sync
  input wire logic [NUM_LINKS-1:0] dev_sync_low_i,
  output logic [NUM_LINKS-1:0] mdev_sync_low_o,
  // Lane data
  input wire logic [NUM_LANES*tx_link_host_pkg::CFG_DATA_W-1:0] lane_stream_i,
  output logic [NUM_LANES*tx_link_host_pkg::CFG_DATA_W-1:0] lane_octet_words_o
);
  localparam int SYNC_REQ_CYC = sync_req_link_cycles(OCTETS_PER_FRAME);
  localparam int ERR_CYC = err_link_cycles(OCTETS_PER_FRAME);

  // Refuse shapes the counters cannot serve
  initial
  begin
    if (NUM_LINKS < 1 || NUM_LANES < 1 || LINK_DIV < 1 || LINK_DIV > 255)
      $error("tx_link_host: bad link, lane or divider parameter");
    if (OCTETS_PER_FRAME < 1 || SYNC_REQ_CYC >= (1 << CNT_W))
      $error("tx_link_host: octets per frame out of range");
  end

  typedef enum logic [1:0] {SY_IDLE, SY_REQUEST, SY_ERROR} sync_state_t;

  cfg_req_if req_bus ();
  logic [2:0] release_cnt;
  logic [7:0] div_cnt;
  logic link_en;
  sync_state_t sync_state;
  logic [CNT_W-1:0] sync_cnt;
  logic mdev_all_low;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration reset: drops with our reset, releases on a clock edge [RULE2]
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      release_cnt <= '0;
      cfg_bus_reset_low_o <= 1'b0;
    end
    else if (release_cnt != 3'(RST_RELEASE_CYCLES))
      release_cnt <= release_cnt + 3'h1;
    else
      cfg_bus_reset_low_o <= 1'b1; // [RULE2]
  end

  // Commands pass only once the port is out of reset [RULE3]
  assign req_bus.port_live = cfg_bus_reset_low_o; // [RULE3]
  assign req_bus.req_valid = cmd_valid_i;
  assign req_bus.req_write = cmd_write_i;
  assign req_bus.req_addr = cmd_addr_i;
  assign req_bus.req_wdata = cmd_wdata_i;

  // Ready is registered a cycle behind the engine's own ready, which alone decides when a command is taken
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      cmd_ready_o <= 1'b0;
    else
      cmd_ready_o <= req_bus.req_ready && !(cmd_valid_i && cmd_ready_o);
  end

  // Answer mirrors the engine by one register stage
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= WORD_RESET;
    end
    else
    begin
      rsp_valid_o <= req_bus.rsp_valid;
      rsp_rdata_o <= req_bus.rsp_rdata;
    end
  end

  cfg_bus_master #(
    .USE_SELECT(USE_SELECT)
  ) u_master (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .req(req_bus.engine),
    .cfg_bus_select_o(cfg_bus_select_o),
    .cfg_bus_word_addr_o(cfg_bus_word_addr_o),
    .cfg_bus_wr_word_o(cfg_bus_wr_word_o),
    .cfg_bus_rd_strobe_o(cfg_bus_rd_strobe_o),
    .cfg_bus_wr_strobe_o(cfg_bus_wr_strobe_o),
    .cfg_bus_rd_word_i(cfg_bus_rd_word_i),
    .cfg_bus_stall_i(cfg_bus_stall_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  // SYSREF passes only in subclass 1, else held low [RULE10]
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      sysref_o <= 1'b0;
    else
      sysref_o <= (subclass_i == SUBCLASS_1) && sysref_i; // [RULE10]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link-cycle enable; durations count link cycles, not system cycles
  assign link_en = (div_cnt == 8'(LINK_DIV - 1));

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i || link_en)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  // Sync line shaper: long low for a request, short low for an error [RULE11]
  // A request wins if both arrive together, since it also resyncs the link
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      sync_state <= SY_IDLE;
      sync_cnt <= '0;
      sync_low_o <= SYNC_IDLE_LEVEL;
      sync_busy_o <= 1'b0;
    end
    else
    begin
      case (sync_state)
        SY_IDLE:
        begin
          if (sync_req_i)
          begin
            sync_cnt <= CNT_W'(SYNC_REQ_CYC - 1); // Five frames plus nine octets [RULE12]
            sync_low_o <= 1'b0;
            sync_busy_o <= 1'b1;
            sync_state <= SY_REQUEST;
          end
          else if (err_report_i)
          begin
            sync_cnt <= CNT_W'(ERR_CYC - 1); // Longer of the two minimums [RULE13]
            sync_low_o <= 1'b0;
            sync_busy_o <= 1'b1;
            sync_state <= SY_ERROR;
          end
        end
        SY_REQUEST, SY_ERROR:
        begin
          if (link_en)
          begin
            if (sync_cnt == '0)
            begin
              sync_low_o <= SYNC_IDLE_LEVEL; // [RULE12] [RULE13]
              sync_busy_o <= 1'b0;
              sync_state <= SY_IDLE;
            end
            else
              sync_cnt <= sync_cnt - CNT_W'(1);
          end
        end
        default: sync_state <= SY_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multidevice sync: any link low pulls all low in subclass 0 [RULE16]
  assign mdev_all_low = !(&dev_sync_low_i);

  generate
    for (genvar k = 0; k < NUM_LINKS; k++)
    begin : g_mdev
      // Subclass 1 and other modes loop each link back to itself [RULE17]
      always_ff @(posedge sys_clk_i)
      begin
        if (!resetn_i)
          mdev_sync_low_o[k] <= SYNC_IDLE_LEVEL;
        else if (subclass_i == SUBCLASS_0)
          mdev_sync_low_o[k] <= !mdev_all_low; // [RULE16]
        else
          mdev_sync_low_o[k] <= dev_sync_low_i[k]; // [RULE17]
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Lane packing: first octet to bits 31:24, lane 0 lowest [RULE19]
  generate
    for (genvar l = 0; l < NUM_LANES; l++)
    begin : g_lane
      always_ff @(posedge sys_clk_i)
      begin
        if (!resetn_i)
          lane_octet_words_o[l*CFG_DATA_W +: CFG_DATA_W] <= WORD_RESET;
        else
          lane_octet_words_o[l*CFG_DATA_W +: CFG_DATA_W] <=
            pack_big_endian(lane_stream_i[l*CFG_DATA_W +: CFG_DATA_W]); // [RULE19]
      end
    end
  endgenerate
endmodule : tx_link_host

// *** logic/tx_link_host_pkg.sv ***
// Constants and helpers shared by the transmit-link host controller
package tx_link_host_pkg;
  // Configuration bus shape
  localparam int CFG_ADDR_W = 8;
  localparam int CFG_DATA_W = 32;
  localparam int OCTET_W = 8;
  localparam int OCTETS_PER_WORD = 4;
  // The configuration reset stays low this many cycles plus one after our own reset releases
  localparam int RST_RELEASE_CYCLES = 4;
  // Sync request: at least five frames plus nine octets
  localparam int SYNC_REQ_FRAMES = 5;
  localparam int SYNC_REQ_OCTETS = 9;
  // Error report: one link cycle or two frame cycles, whichever is longer
  localparam int ERR_LINK_CYCLES = 1;
  localparam int ERR_FRAME_CYCLES = 2;
  // Counter width for link-cycle counts
  localparam int CNT_W = 16;
  // Subclass codes
  localparam logic [1:0] SUBCLASS_0 = 2'h0;
  localparam logic [1:0] SUBCLASS_1 = 2'h1;
  localparam logic [1:0] SUBCLASS_2 = 2'h2;
  // Reset values of driven lines
  localparam logic SYNC_IDLE_LEVEL = 1'b1;
  localparam logic [CFG_DATA_W-1:0] WORD_RESET = 32'h0000_0000;

  // Link cycles (4 octets each) for a sync request, rounded up
  function automatic int sync_req_link_cycles(input int octets_per_frame);
    sync_req_link_cycles = (SYNC_REQ_FRAMES * octets_per_frame + SYNC_REQ_OCTETS
      + OCTETS_PER_WORD - 1) / OCTETS_PER_WORD;
  endfunction : sync_req_link_cycles

  // Link cycles for an error pulse, rounded up, never under one link cycle
  function automatic int err_link_cycles(input int octets_per_frame);
    int frames;
    frames = (ERR_FRAME_CYCLES * octets_per_frame + OCTETS_PER_WORD - 1) / OCTETS_PER_WORD;
    err_link_cycles = (frames > ERR_LINK_CYCLES) ? frames : ERR_LINK_CYCLES;
  endfunction : err_link_cycles

  // Stream-ordered octets (first in bits 7:0) to a big-endian lane word
  function automatic logic [CFG_DATA_W-1:0] pack_big_endian(input logic [CFG_DATA_W-1:0] s);
    pack_big_endian = {s[7:0], s[15:8], s[23:16], s[31:24]};
  endfunction : pack_big_endian
endpackage : tx_link_host_pkg

// *** verif/tb_top.sv ***
// Self-checking bench for the transmit-link host controller
`timescale 1ns/1ps
`define CHK(name, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("ERROR %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module tb_top;
  import tx_link_host_pkg::*;
  localparam int OPF = 1;
  localparam int REQ_LEN = (SYNC_REQ_FRAMES * OPF + SYNC_REQ_OCTETS + 3) / 4;
  localparam int ERR_LEN = 1;
  localparam logic [7:0] AD [3] = '{8'h00, 8'hFF, 8'h01};
  localparam logic [31:0] DT [3] = '{32'hA5A5_0001, 32'h1234_5678, 32'hFFFF_FFFF};
  int fail_count = 0;
  int tests_run = 0;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cmd_valid_i = 1'b0, cmd_write_i = 1'b0, cmd_ready_o, rsp_valid_o;
  logic [7:0] cmd_addr_i = 8'h00, cfg_bus_word_addr_o;
  logic [31:0] cmd_wdata_i = 32'h0, rsp_rdata_o, cfg_bus_wr_word_o, cfg_bus_rd_word_i;
  logic cfg_bus_reset_low_o, cfg_bus_select_o, cfg_bus_rd_strobe_o, cfg_bus_wr_strobe_o;
  logic cfg_bus_stall_i, sysref_o, sync_low_o, sync_busy_o, dev_sync_low, link1_low = 1'b1;
  logic [1:0] subclass_i = 2'h0, mdev_sync_low_o;
  logic sysref_i = 1'b0, sync_req_i = 1'b0, err_report_i = 1'b0;
  logic [63:0] lane_stream_i = 64'h0, lane_octet_words_o;
  //////////////////////////////////////////////////////////////////////////////
  always #12.5 sys_clk_i = ~sys_clk_i;
  tx_link_host #(.NUM_LINKS(2), .NUM_LANES(2), .OCTETS_PER_FRAME(OPF)) dut (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
    .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .cfg_bus_reset_low_o(cfg_bus_reset_low_o), .cfg_bus_select_o(cfg_bus_select_o),
    .cfg_bus_word_addr_o(cfg_bus_word_addr_o), .cfg_bus_wr_word_o(cfg_bus_wr_word_o),
    .cfg_bus_rd_strobe_o(cfg_bus_rd_strobe_o), .cfg_bus_wr_strobe_o(cfg_bus_wr_strobe_o),
    .cfg_bus_rd_word_i(cfg_bus_rd_word_i), .cfg_bus_stall_i(cfg_bus_stall_i),
    .subclass_i(subclass_i), .sysref_i(sysref_i), .sysref_o(sysref_o),
    .sync_req_i(sync_req_i), .err_report_i(err_report_i), .sync_low_o(sync_low_o),
    .sync_busy_o(sync_busy_o), .dev_sync_low_i({link1_low, dev_sync_low}),
    .mdev_sync_low_o(mdev_sync_low_o), .lane_stream_i(lane_stream_i),
    .lane_octet_words_o(lane_octet_words_o));
  tx_core_model u_dev (
    .sys_clk_i(sys_clk_i), .cfg_bus_reset_low_i(cfg_bus_reset_low_o),
    .cfg_bus_select_i(cfg_bus_select_o), .cfg_bus_word_addr_i(cfg_bus_word_addr_o),
    .cfg_bus_wr_word_i(cfg_bus_wr_word_o), .cfg_bus_rd_strobe_i(cfg_bus_rd_strobe_o),
    .cfg_bus_wr_strobe_i(cfg_bus_wr_strobe_o), .cfg_bus_rd_word_o(cfg_bus_rd_word_i),
    .cfg_bus_stall_o(cfg_bus_stall_i), .sync_low_i(sync_low_o),
    .dev_sync_low_o(dev_sync_low));
  //////////////////////////////////////////////////////////////////////////////
  // Every drive and sample lands 1 ns after the rising edge
  task automatic step();
    @(posedge sys_clk_i);
    #1;
  endtask : step
  // One command, answer expected two edges after the take
  task automatic do_cmd(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 50)
    begin
      step();
      n++;
    end
    cmd_valid_i = 1'b1;
    cmd_write_i = wr;
    cmd_addr_i = a;
    cmd_wdata_i = d;
    step();
    cmd_valid_i = 1'b0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 10)
    begin
      step();
      n++;
    end
    `CHK("rsp_latency", 2, n)
  endtask : do_cmd
  task automatic test_reset();
    int n;
    repeat (20) step();
    `CHK("cfg_reset_in_reset", 1'b0, cfg_bus_reset_low_o)
    `CHK("sync_idle", SYNC_IDLE_LEVEL, sync_low_o)
    resetn_i = 1'b1;
    n = 0;
    while (cfg_bus_reset_low_o !== 1'b1 && n < 20)
    begin
      `CHK("no_ready_early", 1'b0, cmd_ready_o)
      step();
      n++;
    end
    `CHK("cfg_reset_release", 1 + RST_RELEASE_CYCLES, n)
    step();
    `CHK("select_idle", 1'b0, cfg_bus_select_o)
    $display("test_reset done");
  endtask : test_reset
  task automatic test_regs();
    for (int i = 0; i < 3; i++)
    begin
      do_cmd(1'b1, AD[i], DT[i]);
      `CHK("dev_word", DT[i], u_dev.mem[AD[i]])
    end
    // Software sync start pulls the clean line low, then the combine follows it
    do_cmd(1'b1, 8'h10, 32'h0000_0001);
    `CHK("sw_sync", 2'b00, mdev_sync_low_o)
    do_cmd(1'b1, 8'h10, 32'h0000_0000);
    `CHK("sw_sync_end", 2'b11, mdev_sync_low_o)
    for (int i = 2; i >= 0; i--)
    begin
      do_cmd(1'b0, AD[i], 32'h0);
      `CHK("read_word", DT[i], rsp_rdata_o)
    end
    $display("test_regs done");
  endtask : test_regs
  task automatic test_link_paths();
    sysref_i = 1'b1;
    link1_low = 1'b0;
    lane_stream_i = 64'h8877_6655_4433_2211;
    for (int s = 0; s < 3; s++)
    begin
      subclass_i = s[1:0];
      step();
      step();
      `CHK("sysref", (s == 1), sysref_o)
      `CHK("mdev", (s == 0) ? 2'b00 : 2'b01, mdev_sync_low_o)
    end
    `CHK("lanes", 64'h5566_7788_1122_3344, lane_octet_words_o)
    sysref_i = 1'b0;
    link1_low = 1'b1;
    $display("test_link_paths done");
  endtask : test_link_paths
  // A further error request while busy must not stretch or repeat the low
  task automatic sync_pulse(input logic req, input int len, input logic dev);
    int n;
    logic seen;
    n = 0;
    seen = 1'b1;
    sync_req_i = req;
    err_report_i = 1'b1;
    step();
    sync_req_i = 1'b0;
    while (sync_low_o === 1'b0 && n < 20)
    begin
      seen &= dev_sync_low;
      step();
      n++;
      err_report_i = 1'b0;
    end
    `CHK("sync_low_len", len, n)
    repeat (3) step();
    `CHK("sync_stays_idle", 1'b1, sync_low_o)
    `CHK("clean_sync", dev, seen)
  endtask : sync_pulse
  task automatic test_sync();
    sync_pulse(1'b1, REQ_LEN, 1'b0);
    sync_pulse(1'b0, ERR_LEN, 1'b1);
    $display("test_sync done");
  endtask : test_sync
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    test_reset();
    test_regs();
    test_link_paths();
    test_sync();
    give_verdict();
  end
  // Whole run needs under a hundred cycles; give it 3000, over thirty times that
  initial
  begin
    #(25 * 3000);
    fail_count++;
    give_verdict();
  end
endmodule : tb_top

// *** verif/tx_core_model.sv ***
// Behavioural model of the transmit core: configuration slave and sync cleaner
`timescale 1ns/1ps
module tx_core_model
  import tx_link_host_pkg::*;
(
  // Clock and configuration reset
  input wire logic sys_clk_i,
  input wire logic cfg_bus_reset_low_i,
  // Configuration slave
  input wire logic cfg_bus_select_i,
  input wire logic [CFG_ADDR_W-1:0] cfg_bus_word_addr_i,
  input wire logic [CFG_DATA_W-1:0] cfg_bus_wr_word_i,
  input wire logic cfg_bus_rd_strobe_i,
  input wire logic cfg_bus_wr_strobe_i,
  output logic [CFG_DATA_W-1:0] cfg_bus_rd_word_o,
  output logic cfg_bus_stall_o,
  // Sync lines
  input wire logic sync_low_i,
  output logic dev_sync_low_o
);
  logic [CFG_DATA_W-1:0] mem [256];
  logic [CFG_DATA_W-1:0] last_rd = 32'h5A5A_5A5A;
  logic [3:0] low_cnt;
  logic sw_sync = 1'b0;
  // Software sync start word; the address is arbitrary for this model
  localparam logic [7:0] SW_SYNC_WORD = 8'h10;
  //////////////////////////////////////////////////////////////////////////////
  // Never stalls, so every access completes in its own cycle
  assign cfg_bus_stall_o = 1'b0;
  // Outside a selected read the bus shows a changing pattern, never stale data
  assign cfg_bus_rd_word_o = (cfg_bus_select_i && cfg_bus_rd_strobe_i) ?
    mem[cfg_bus_word_addr_i] : ~last_rd;
  // Word-indexed store, only selected writes after config reset release
  always @(posedge sys_clk_i)
  begin
    last_rd <= cfg_bus_rd_word_o;
    if (cfg_bus_reset_low_i && cfg_bus_select_i && cfg_bus_wr_strobe_i)
    begin
      mem[cfg_bus_word_addr_i] <= cfg_bus_wr_word_i;
    end
  end
  // Bit 0 of the sync start word holds a software-started sync
  always @(posedge sys_clk_i)
  begin
    if (!cfg_bus_reset_low_i)
      sw_sync <= 1'b0;
    else if (cfg_bus_select_i && cfg_bus_wr_strobe_i && cfg_bus_word_addr_i == SW_SYNC_WORD)
      sw_sync <= cfg_bus_wr_word_i[0];
  end
  // Lows longer than an error pulse are requests; short pulses are masked
  // The sync line is registered in the model's own clock before use
  always @(posedge sys_clk_i)
  begin
    if (!cfg_bus_reset_low_i || sync_low_i)
      low_cnt <= 4'h0;
    else if (low_cnt != 4'hF)
      low_cnt <= low_cnt + 4'h1;
  end
  assign dev_sync_low_o = (low_cnt < 4'h2) && !sw_sync;
endmodule : tx_core_model

// *** verif/tx_link_host_sva.sv ***
// Concurrent checks on the host controller's ports
`timescale 1ns/1ps
module tx_link_host_sva
  import tx_link_host_pkg::*;
#(
  parameter int NUM_LINKS = 1
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Command port
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [CFG_ADDR_W-1:0] cmd_addr_i,
  input wire logic [CFG_DATA_W-1:0] cmd_wdata_i,
  input wire logic cmd_ready_o,
  input wire logic rsp_valid_o,
  input wire logic [CFG_DATA_W-1:0] rsp_rdata_o,
  // Configuration bus
  input wire logic cfg_bus_reset_low_o,
  input wire logic cfg_bus_select_o,
  input wire logic [CFG_ADDR_W-1:0] cfg_bus_word_addr_o,
  input wire logic [CFG_DATA_W-1:0] cfg_bus_wr_word_o,
  input wire logic cfg_bus_rd_strobe_o,
  input wire logic cfg_bus_wr_strobe_o,
  input wire logic [CFG_DATA_W-1:0] cfg_bus_rd_word_i,
  input wire logic cfg_bus_stall_i,
  // Link control
  input wire logic [1:0] subclass_i,
  input wire logic sysref_i,
  input wire logic sysref_o,
  input wire logic sync_req_i,
  input wire logic err_report_i,
  input wire logic sync_low_o,
  input wire logic sync_busy_o,
  input wire logic [NUM_LINKS-1:0] dev_sync_low_i,
  input wire logic [NUM_LINKS-1:0] mdev_sync_low_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  //////////////////////////////////////////////////////////////////////////////
  property p_strobe_excl;
    !(cfg_bus_rd_strobe_o && cfg_bus_wr_strobe_o);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("read and write strobes high together");
  property p_no_early_access;
    !cfg_bus_reset_low_o |-> !(cfg_bus_rd_strobe_o || cfg_bus_wr_strobe_o);
  endproperty
  a_no_early_access: assert property (p_no_early_access)
    else $error("access while config reset low");
  property p_select_qual;
    (cfg_bus_rd_strobe_o || cfg_bus_wr_strobe_o) |-> cfg_bus_select_o;
  endproperty
  a_select_qual: assert property (p_select_qual)
    else $error("strobe without select");
  property p_single_cycle;
    (cfg_bus_rd_strobe_o || cfg_bus_wr_strobe_o) && !cfg_bus_stall_i
      |=> !(cfg_bus_rd_strobe_o || cfg_bus_wr_strobe_o);
  endproperty
  a_single_cycle: assert property (p_single_cycle)
    else $error("strobe held without stall");
  property p_read_return;
    cfg_bus_rd_strobe_o && !cfg_bus_stall_i
      |-> ##2 rsp_valid_o && rsp_rdata_o == $past(cfg_bus_rd_word_i, 2);
  endproperty
  a_read_return: assert property (p_read_return)
    else $error("read word not returned from access cycle");
  property p_write_issue;
    cmd_valid_i && cmd_ready_o && cmd_write_i |=> cfg_bus_wr_strobe_o
      && cfg_bus_word_addr_o == $past(cmd_addr_i) && cfg_bus_wr_word_o == $past(cmd_wdata_i);
  endproperty
  a_write_issue: assert property (p_write_issue)
    else $error("write not issued with command address and word");
  property p_sysref;
    $past(resetn_i) |-> sysref_o == ($past(subclass_i) == SUBCLASS_1 && $past(sysref_i));
  endproperty
  a_sysref: assert property (p_sysref)
    else $error("sysref not gated by subclass");
  // Counts below hold for one octet per frame and a link divider of one
  property p_sync_req;
    !sync_busy_o && sync_req_i |=> !sync_low_o [*4] ##1 sync_low_o;
  endproperty
  a_sync_req: assert property (p_sync_req)
    else $error("sync request low time wrong");
  property p_sync_err;
    !sync_busy_o && !sync_req_i && err_report_i |=> !sync_low_o ##1 sync_low_o;
  endproperty
  a_sync_err: assert property (p_sync_err)
    else $error("error pulse low time wrong");
  property p_mdev_comb;
    $past(resetn_i) && $past(subclass_i) == SUBCLASS_0
      |-> mdev_sync_low_o == {NUM_LINKS{&$past(dev_sync_low_i)}};
  endproperty
  a_mdev_comb: assert property (p_mdev_comb)
    else $error("multidevice sync not combined");
endmodule : tx_link_host_sva

bind tx_link_host tx_link_host_sva #(.NUM_LINKS(NUM_LINKS)) u_sva (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
  .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i),
  .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
  .cfg_bus_reset_low_o(cfg_bus_reset_low_o), .cfg_bus_select_o(cfg_bus_select_o),
  .cfg_bus_word_addr_o(cfg_bus_word_addr_o), .cfg_bus_wr_word_o(cfg_bus_wr_word_o),
  .cfg_bus_rd_strobe_o(cfg_bus_rd_strobe_o), .cfg_bus_wr_strobe_o(cfg_bus_wr_strobe_o),
  .cfg_bus_rd_word_i(cfg_bus_rd_word_i), .cfg_bus_stall_i(cfg_bus_stall_i),
  .subclass_i(subclass_i), .sysref_i(sysref_i), .sysref_o(sysref_o),
  .sync_req_i(sync_req_i), .err_report_i(err_report_i), .sync_low_o(sync_low_o),
  .sync_busy_o(sync_busy_o), .dev_sync_low_i(dev_sync_low_i),
  .mdev_sync_low_o(mdev_sync_low_o));
